// File: logic/lhp_defs.vh
// constants for the host bus port: register offsets, fields, states, timing
`ifndef LHP_DEFS_VH
`define LHP_DEFS_VH
`define LHP_OFF_CTRL 8'h00
`define LHP_OFF_STAT 8'h04
`define LHP_OFF_CTL_STAT_REG_ZERO 8'h08
`define LHP_OFF_CTL_STAT_REG_FOUR 8'h0C
`define LHP_OFF_DMA_ADDR 8'h10
`define LHP_OFF_DMA_WDATA 8'h14
`define LHP_OFF_DMA_RDATA 8'h18
`define LHP_OFF_SLV_RDATA 8'h1C
`define LHP_OFF_SLV_WDATA 8'h20
`define LHP_ADDR_W 8
`define LHP_CTL_STAT_REG_ZERO_IRQ_EN 9
`define LHP_CTL_STAT_REG_ZERO_FLAG_LO 0
`define LHP_CTL_STAT_REG_ZERO_FLAG_W 7
`define LHP_CTL_STAT_REG_FOUR_BUS_STYLE 0
`define LHP_CTL_STAT_REG_FOUR_BURST_REL 6
`define LHP_CTRL_GO 0
`define LHP_CTRL_RD 1
`define LHP_CTRL_MASK_LO 2
`define LHP_CTRL_MASK_HI 3
`define LHP_CTRL_RESET 32'h0000_0000
`define LHP_CTL_STAT_REG_ZERO_RESET 16'h0000
`define LHP_CTL_STAT_REG_FOUR_RESET 16'h0000
`define LHP_MASK_WORD 2'h0
`define LHP_MASK_ILLEGAL 2'h3
`define LHP_ST_IDLE 3'h0
`define LHP_ST_ADDR 3'h1
`define LHP_ST_DATA 3'h2
`define LHP_ST_WAIT 3'h3
`define LHP_ST_DONE 3'h4
`define LHP_PHASE_NS 8
`define LHP_CLK_NS 4
`define LHP_SYNC_DEPTH 2
`define LHP_PHASE_CYC ((`LHP_PHASE_NS + `LHP_CLK_NS - 1) / `LHP_CLK_NS)
`endif

// File: logic/lhp_host_bus_port.v
// host-side multiplexed address/data bus port with ahb-lite register slave
// How it works
// [RQ1] address phase drives low eight address bits on lane bits 7:0
// [RQ2] data phase carries read or write data; direction picks the driver
// [RQ3] direction pin driven only as master, steady whole transfer, else released
// [RQ4] as slave, host direction high: we drive lane; low: we sample lane
// [RQ5] as master, direction high for memory read, low for memory write
// [RQ6] attention irq asserts when enable bit 9 set and any of seven flags
// [RQ7] inbound transceiver control active only in master read data phase
// [RQ8] outbound control during read address phase and whole write transfer
// [RQ9] transceiver controls driven only as master, released otherwise
// [RQ10] data strobe marks data phase; data stable at its rising edge
// [RQ11] data strobe driven only as master, released otherwise
// [RQ12] control bit 6 set: pin becomes burst release input ending dma burst
// [RQ13] control bit 6 clear: pin is output mirroring its companion mask pin; code drives mask bit 0 on it instead
// [RQ14] bus style bit 0 clear: two pins are three-state byte mask outputs
// [RQ15] byte mask shows which lane bytes the current transfer uses
// [RQ16] mask 00 word, 01 upper byte, 10 lower byte, 11 illegal
// [RQ17] byte mask driven only as master, ignored as slave
// [RQ18] host holds port select low for data port, high for address port
// [RQ19] slave ready asserts after strobe when data placed, drops after strobe
// [RQ20] irq releases when flags clear or enable cleared; inactive after reset
//
// The register offsets and the AHB-Lite slave port were chosen for this implementation.
`timescale 1ns/1ps
`include "lhp_defs.vh"
module lhp_host_bus_port (
    input wire hclk,
    input wire hresetn,
    input wire hsel,
    input wire [31:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [2:0] hsize,
    input wire [31:0] hwdata,
    input wire hready,
    output wire hreadyout,
    output wire hresp,
    output reg [31:0] hrdata,
    input wire [15:0] lane_in,
    output reg [15:0] lane_out,
    output reg lane_oe,
    input wire dir_in,
    output reg dir_out,
    output reg dir_oe,
    input wire strobe_in,
    output reg data_phase_strobe,
    output reg strobe_oe,
    output reg xcvr_inbound_enable_n,
    output reg xcvr_outbound_enable_n,
    output reg xcvr_oe,
    input wire byte_lane_mask_0_in,
    output reg byte_lane_mask_0,
    output reg byte_lane_mask_0_oe,
    output reg byte_lane_mask_1,
    output reg byte_lane_mask_1_oe,
    input wire hold_grant_n,
    input wire chip_sel_n,
    input wire port_sel,
    output reg slave_ready_n_out,
    output reg slave_ready_oe,
    output reg attention_irq_n_out,
    output reg attention_irq_oe
);
    // async pin inputs pass two flops before use
    reg [15:0] lane_s1_q, lane_s2_q;
    reg [5:0] pin_s1_q, pin_s2_q;
    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            lane_s1_q <= 16'h0000;
            lane_s2_q <= 16'h0000;
            pin_s1_q <= 6'h3F;
            pin_s2_q <= 6'h3F;
        end
        else
        begin
            lane_s1_q <= lane_in;
            lane_s2_q <= lane_s1_q;
            pin_s1_q <= {dir_in, strobe_in, byte_lane_mask_0_in, hold_grant_n,
                chip_sel_n, port_sel};
            pin_s2_q <= pin_s1_q;
        end
    end
    wire dir_s = pin_s2_q[5];
    wire strobe_s = pin_s2_q[4];
    wire burst_rel_s = pin_s2_q[3];
    wire grant_s = ~pin_s2_q[2];
    wire cs_s = ~pin_s2_q[1];
    wire port_s = pin_s2_q[0];

    // ahb-lite slave: zero wait state, always okay
    reg ph_q;
    reg ph_wr_q;
    reg [`LHP_ADDR_W-1:0] ph_addr_q;
    reg [31:0] ctrl_q;
    reg [15:0] ctl_stat_reg_zero_q, ctl_stat_reg_four_q;
    reg [23:0] dma_addr_q;
    reg [15:0] dma_wdata_q, dma_rdata_q, slv_rdata_q, slv_wdata_q;
    reg [7:0] reg_ptr_q;
    reg [2:0] st_q;
    reg [1:0] cnt_q;
    reg burst_stop_q;
    reg slv_strobe_q;
    reg [`LHP_SYNC_DEPTH-1:0] rd_cap_q;
    wire slv_data_take;
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    wire take = hsel & htrans[1] & hready;
    wire wr_go = ph_q & ph_wr_q & (ph_addr_q == `LHP_OFF_CTRL) & hwdata[`LHP_CTRL_GO];
    wire busy = (st_q != `LHP_ST_IDLE);
    wire [1:0] mask_sel = ctrl_q[`LHP_CTRL_MASK_HI:`LHP_CTRL_MASK_LO];
    wire slv_strobe_rise;
    wire slv_wr_take;

    function [31:0] rd_mux;
        input [`LHP_ADDR_W-1:0] a;
        begin
            case (a)
                `LHP_OFF_CTRL: rd_mux = ctrl_q;
                `LHP_OFF_STAT: rd_mux = {27'h000_0000, burst_stop_q, st_q, 1'b0};
                `LHP_OFF_CTL_STAT_REG_ZERO: rd_mux = {16'h0000, ctl_stat_reg_zero_q};
                `LHP_OFF_CTL_STAT_REG_FOUR: rd_mux = {16'h0000, ctl_stat_reg_four_q};
                `LHP_OFF_DMA_ADDR: rd_mux = {8'h00, dma_addr_q};
                `LHP_OFF_DMA_WDATA: rd_mux = {16'h0000, dma_wdata_q};
                `LHP_OFF_DMA_RDATA: rd_mux = {16'h0000, dma_rdata_q};
                `LHP_OFF_SLV_RDATA: rd_mux = {16'h0000, slv_rdata_q};
                `LHP_OFF_SLV_WDATA: rd_mux = {16'h0000, slv_wdata_q};
                default: rd_mux = 32'h0000_0000;
            endcase
        end
    endfunction

    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            ph_q <= 1'b0;
            ph_wr_q <= 1'b0;
            ph_addr_q <= 8'h00;
            hrdata <= 32'h0000_0000;
        end
        else
        begin
            ph_q <= take;
            ph_wr_q <= hwrite;
            ph_addr_q <= haddr[`LHP_ADDR_W-1:0];
            if (take && !hwrite)
                hrdata <= rd_mux(haddr[`LHP_ADDR_W-1:0]);
        end
    end

    // software registers; hardware flag set wins over software clear
    wire [6:0] flag_set = {5'h00, slv_data_take, 1'b0};
    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            ctrl_q <= `LHP_CTRL_RESET;
            ctl_stat_reg_zero_q <= `LHP_CTL_STAT_REG_ZERO_RESET;
            ctl_stat_reg_four_q <= `LHP_CTL_STAT_REG_FOUR_RESET;
            dma_addr_q <= 24'h00_0000;
            dma_wdata_q <= 16'h0000;
            slv_rdata_q <= 16'h0000;
        end
        else
        begin
            if (ph_q && ph_wr_q)
            begin
                case (ph_addr_q)
                    `LHP_OFF_CTRL: ctrl_q <= {hwdata[31:1], 1'b0};
                    `LHP_OFF_CTL_STAT_REG_ZERO: ctl_stat_reg_zero_q[15:7] <= hwdata[15:7];
                    `LHP_OFF_CTL_STAT_REG_FOUR: ctl_stat_reg_four_q <= hwdata[15:0];
                    `LHP_OFF_DMA_ADDR: dma_addr_q <= hwdata[23:0];
                    `LHP_OFF_DMA_WDATA: dma_wdata_q <= hwdata[15:0];
                    `LHP_OFF_SLV_RDATA: slv_rdata_q <= hwdata[15:0];
                    default: ;
                endcase
            end
            ctl_stat_reg_zero_q[6:0] <= ((ph_q && ph_wr_q && ph_addr_q == `LHP_OFF_CTL_STAT_REG_ZERO) ?
                (ctl_stat_reg_zero_q[6:0] & ~hwdata[6:0]) : ctl_stat_reg_zero_q[6:0]) | flag_set;
        end
    end

    // master engine: wait grant, address phase, data phase, done
    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            st_q <= `LHP_ST_IDLE;
            cnt_q <= 2'h0;
            dma_rdata_q <= 16'h0000;
            burst_stop_q <= 1'b0;
            rd_cap_q <= {`LHP_SYNC_DEPTH{1'b0}};
        end
        else
        begin
            // [RQ10] read word taken once the strobe-rise lane value leaves the synchroniser
            rd_cap_q <= {rd_cap_q[`LHP_SYNC_DEPTH-2:0],
                (st_q == `LHP_ST_DONE) & ctrl_q[`LHP_CTRL_RD]};
            if (rd_cap_q[`LHP_SYNC_DEPTH-1])
                dma_rdata_q <= lane_s2_q;
            case (st_q)
                `LHP_ST_IDLE:
                    if (wr_go)
                    begin
                        st_q <= `LHP_ST_WAIT;
                        burst_stop_q <= 1'b0;
                    end
                `LHP_ST_WAIT:
                    if (grant_s)
                    begin
                        st_q <= `LHP_ST_ADDR;
                        cnt_q <= 2'h0;
                    end
                `LHP_ST_ADDR:
                    if (cnt_q == `LHP_PHASE_CYC - 1)
                    begin
                        st_q <= `LHP_ST_DATA;
                        cnt_q <= 2'h0;
                    end
                    else
                        cnt_q <= cnt_q + 2'h1;
                `LHP_ST_DATA:
                    if (cnt_q == `LHP_PHASE_CYC - 1)
                    begin
                        st_q <= `LHP_ST_DONE;
                    end
                    else
                        cnt_q <= cnt_q + 2'h1;
                `LHP_ST_DONE:
                begin
                    // [RQ12] burst release ends burst after current transfer
                    if (ctl_stat_reg_four_q[`LHP_CTL_STAT_REG_FOUR_BURST_REL] && !burst_rel_s)
                        burst_stop_q <= 1'b1;
                    st_q <= `LHP_ST_IDLE;
                end
                default: st_q <= `LHP_ST_IDLE;
            endcase
        end
    end

    // pin drive, registered so outputs come from flops
    wire master = (st_q == `LHP_ST_ADDR) | (st_q == `LHP_ST_DATA);
    wire rd = ctrl_q[`LHP_CTRL_RD];
    wire in_data = (st_q == `LHP_ST_DATA);
    wire [1:0] mask_enc = (mask_sel == `LHP_MASK_ILLEGAL) ? `LHP_MASK_WORD : mask_sel;
    // [RQ10] host write data taken at the strobe's low-to-high edge
    assign slv_strobe_rise = cs_s & strobe_s & ~slv_strobe_q;
    assign slv_wr_take = slv_strobe_rise & ~dir_s;
    assign slv_data_take = slv_wr_take & ~port_s;
    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            lane_out <= 16'h0000;
            lane_oe <= 1'b0;
            dir_out <= 1'b0;
            dir_oe <= 1'b0;
            data_phase_strobe <= 1'b1;
            strobe_oe <= 1'b0;
            xcvr_inbound_enable_n <= 1'b1;
            xcvr_outbound_enable_n <= 1'b1;
            xcvr_oe <= 1'b0;
            byte_lane_mask_0 <= 1'b0;
            byte_lane_mask_0_oe <= 1'b0;
            byte_lane_mask_1 <= 1'b0;
            byte_lane_mask_1_oe <= 1'b0;
            slave_ready_n_out <= 1'b0;
            slave_ready_oe <= 1'b0;
            // idle strobe level, so no false edge follows reset
            slv_strobe_q <= 1'b1;
            slv_wdata_q <= 16'h0000;
            attention_irq_n_out <= 1'b0;
            attention_irq_oe <= 1'b0;
        end
        else
        begin
            slv_strobe_q <= strobe_s;
            // [RQ1] address phase puts low address byte on lane
            // [RQ2] data phase: we drive only on master writes or slave reads
            // [RQ4] slave direction high means we drive the lane
            if (st_q == `LHP_ST_ADDR)
                lane_out <= {8'h00, dma_addr_q[7:0]};
            else if (master)
                lane_out <= dma_wdata_q;
            else
                lane_out <= port_s ? {8'h00, reg_ptr_q} : slv_rdata_q;
            lane_oe <= (master & ((st_q == `LHP_ST_ADDR) | ~rd)) |
                (cs_s & dir_s & ~strobe_s);
            // [RQ3] [RQ5] direction driven by master, high means memory read
            dir_out <= rd;
            dir_oe <= master;
            // [RQ11] strobe driven as master only; low during data phase
            data_phase_strobe <= ~in_data;
            strobe_oe <= master;
            // [RQ7] [RQ8] [RQ9] transceiver controls as master only
            xcvr_inbound_enable_n <= ~(in_data & rd);
            xcvr_outbound_enable_n <= ~((st_q == `LHP_ST_ADDR) | ~rd);
            xcvr_oe <= master;
            // [RQ14] [RQ15] [RQ16] [RQ17] byte mask when bus style clear, master
            byte_lane_mask_1 <= mask_enc[1];
            byte_lane_mask_1_oe <= master & ~ctl_stat_reg_four_q[`LHP_CTL_STAT_REG_FOUR_BUS_STYLE];
            // [RQ13] shared pin carries mask bit 0 unless burst release
            byte_lane_mask_0 <= mask_enc[0];
            byte_lane_mask_0_oe <= master & ~ctl_stat_reg_four_q[`LHP_CTL_STAT_REG_FOUR_BURST_REL];
            // [RQ19] slave ready follows strobe, drops after strobe negates
            slave_ready_oe <= cs_s & ~strobe_s;
            if (slv_data_take)
                slv_wdata_q <= lane_s2_q;
            // [RQ6] [RQ20] open drain irq: enable and any flag
            attention_irq_oe <= ctl_stat_reg_zero_q[`LHP_CTL_STAT_REG_ZERO_IRQ_EN] &
                (|ctl_stat_reg_zero_q[`LHP_CTL_STAT_REG_ZERO_FLAG_LO +: `LHP_CTL_STAT_REG_ZERO_FLAG_W]);
        end
    end

    // [RQ18] host port select high writes register pointer
    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            reg_ptr_q <= 8'h00;
        else if (slv_wr_take && port_s)
            reg_ptr_q <= lane_s2_q[7:0];
    end
endmodule // lhp_host_bus_port

// File: testbench/lhp_mem_model.sv
// memory and bus arbiter model on the far side of the host bus port
`timescale 1ns/1ps
module lhp_mem_model (
    input wire hclk,
    input wire grant,
    input wire [15:0] rd_word,
    input wire [15:0] lane_out,
    input wire lane_oe,
    input wire dir_out,
    input wire data_phase_strobe,
    input wire strobe_oe,
    input wire byte_lane_mask_0,
    input wire byte_lane_mask_1,
    output logic hold_grant_n,
    output logic [15:0] lane_in = 16'h0000,
    output logic [7:0] addr_q,
    output logic [15:0] wdata_q,
    output logic [1:0] mask_q,
    output int done_cnt = 0
);
    logic stb_q = 1'b1;
    assign hold_grant_n = !grant;
    always @(posedge hclk)
    begin
        stb_q <= data_phase_strobe;
        if (strobe_oe && data_phase_strobe && lane_oe)
        begin
            addr_q <= lane_out[7:0];
            mask_q <= {byte_lane_mask_1, byte_lane_mask_0};
        end
        // write data taken during the strobe
        if (strobe_oe && !data_phase_strobe && !dir_out)
            wdata_q <= lane_out;
        if (data_phase_strobe && !stb_q)
            done_cnt <= done_cnt + 1;
        // memory drives only a read data phase, else a moving pattern
        if (strobe_oe && !data_phase_strobe && dir_out && !lane_oe)
            lane_in <= rd_word;
        else
            lane_in <= ~lane_in;
    end
endmodule // lhp_mem_model

// File: testbench/lhp_host_bus_port_assertions.sv
// concurrent checks on the host bus port pins
`timescale 1ns/1ps
module lhp_host_bus_port_assertions (
    input wire hclk,
    input wire hresetn,
    input wire [15:0] lane_out,
    input wire lane_oe,
    input wire dir_out,
    input wire dir_oe,
    input wire data_phase_strobe,
    input wire strobe_oe,
    input wire xcvr_inbound_enable_n,
    input wire xcvr_outbound_enable_n,
    input wire xcvr_oe,
    input wire byte_lane_mask_0,
    input wire byte_lane_mask_1,
    input wire byte_lane_mask_1_oe
);
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    sequence s_addr;
        strobe_oe && data_phase_strobe && lane_oe;
    endsequence
    sequence s_data;
        strobe_oe && !data_phase_strobe;
    endsequence
    property p_own; strobe_oe |-> dir_oe && xcvr_oe; endproperty
    a_own: assert property (p_own)
        else $error("pins driven while not owner");
    property p_dir; dir_oe && $past(dir_oe) |-> $stable(dir_out); endproperty
    a_dir: assert property (p_dir)
        else $error("direction moved in transfer");
    property p_rd; s_data ##0 dir_out |-> !xcvr_inbound_enable_n && !lane_oe; endproperty
    a_rd: assert property (p_rd)
        else $error("read data phase lane control wrong");
    property p_wr; xcvr_oe && !dir_out |-> xcvr_inbound_enable_n && !xcvr_outbound_enable_n;
    endproperty
    a_wr: assert property (p_wr)
        else $error("write transceiver control wrong");
    property p_adr; s_addr |-> !xcvr_outbound_enable_n && xcvr_inbound_enable_n; endproperty
    a_adr: assert property (p_adr)
        else $error("address phase outbound off");
    property p_msk; byte_lane_mask_1_oe |-> !(byte_lane_mask_0 && byte_lane_mask_1);
    endproperty
    a_msk: assert property (p_msk)
        else $error("illegal byte mask driven");
    property p_mown; byte_lane_mask_1_oe |-> xcvr_oe; endproperty
    a_mown: assert property (p_mown)
        else $error("byte mask driven while not owner");
    property p_ph; s_addr ##1 s_data |=> s_data ##1 (data_phase_strobe || !strobe_oe);
    endproperty
    a_ph: assert property (p_ph)
        else $error("data phase length wrong");
    property p_hold; s_data ##1 (s_data ##0 !dir_out) |-> $stable(lane_out); endproperty
    a_hold: assert property (p_hold)
        else $error("write data moved in strobe");
endmodule // lhp_host_bus_port_assertions
bind lhp_host_bus_port lhp_host_bus_port_assertions u_chk (.hclk(hclk), .hresetn(hresetn),
    .lane_out(lane_out), .lane_oe(lane_oe), .dir_out(dir_out), .dir_oe(dir_oe),
    .data_phase_strobe(data_phase_strobe), .strobe_oe(strobe_oe), .xcvr_oe(xcvr_oe),
    .xcvr_inbound_enable_n(xcvr_inbound_enable_n), .byte_lane_mask_0(byte_lane_mask_0),
    .xcvr_outbound_enable_n(xcvr_outbound_enable_n), .byte_lane_mask_1(byte_lane_mask_1),
    .byte_lane_mask_1_oe(byte_lane_mask_1_oe));

// File: testbench/tb_lhp_host_bus_port.sv
// self-checking bench for the host bus port
`timescale 1ns/1ps
`include "lhp_defs.vh"
module tb_lhp_host_bus_port;
    logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, grant = 0, dir_in = 0;
    logic strobe_in = 1, chip_sel_n = 1, port_sel = 0;
    logic [1:0] htrans = 2'h0;
    logic [31:0] haddr = 0, hwdata = 0, rdat;
    logic burst_rel_n = 1, host_drv = 0;
    logic [15:0] rd_word = 0, host_word = 0, hw, mem_lane, lane_out, wdata_q;
    logic [7:0] rst_offs [4] = '{`LHP_OFF_CTRL, `LHP_OFF_CTL_STAT_REG_ZERO, `LHP_OFF_CTL_STAT_REG_FOUR, 8'h40};
    wire [15:0] lane_in = host_drv ? host_word : mem_lane;
    logic [7:0] addr_q;
    logic [1:0] mask_q;
    wire hready, lane_oe, dir_out, dir_oe, data_phase_strobe, strobe_oe, xcvr_oe;
    wire xcvr_inbound_enable_n, xcvr_outbound_enable_n, hold_grant_n;
    wire byte_lane_mask_0, byte_lane_mask_1, byte_lane_mask_1_oe, byte_lane_mask_0_oe;
    wire slave_ready_oe, attention_irq_oe;
    wire [31:0] hrdata;
    int err_total = 0, n_tests = 0, done_cnt;
    initial forever #2 hclk = ~hclk;
    lhp_host_bus_port dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
        .hsize(3'h2), .hwdata, .hready, .hreadyout(hready), .hresp(), .hrdata,
        .lane_in, .lane_out, .lane_oe, .dir_in, .dir_out, .dir_oe, .strobe_in,
        .data_phase_strobe, .strobe_oe, .xcvr_inbound_enable_n, .xcvr_outbound_enable_n,
        .xcvr_oe, .byte_lane_mask_0_in(burst_rel_n), .byte_lane_mask_0, .byte_lane_mask_0_oe,
        .byte_lane_mask_1, .byte_lane_mask_1_oe, .hold_grant_n, .chip_sel_n, .port_sel,
        .slave_ready_n_out(), .slave_ready_oe, .attention_irq_n_out(), .attention_irq_oe);
    lhp_mem_model mem (.hclk, .grant, .rd_word, .lane_out, .lane_oe, .dir_out,
        .data_phase_strobe, .strobe_oe, .byte_lane_mask_0, .byte_lane_mask_1,
        .hold_grant_n, .lane_in(mem_lane), .addr_q, .wdata_q, .mask_q, .done_cnt);
    task automatic close_out;
        $display("checks %0d, mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            err_total++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
        hsel <= 1;
        htrans <= 2'h2;
        haddr <= {24'h00_0000, a};
        hwrite <= w;
        do @(posedge hclk); while (hready !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hready !== 1'b1);
        rdat = hrdata;
    endtask
    // illegal mask is sent as a whole word
    function automatic logic [1:0] exp_mask(input logic [1:0] m);
        return (m == 2'h3) ? 2'h0 : m;
    endfunction
    task automatic dma(input logic rd, input logic [1:0] m, input logic [15:0] a, d);
        int c0;
        c0 = done_cnt;
        ahb(1, `LHP_OFF_DMA_ADDR, {16'h0000, a});
        ahb(1, `LHP_OFF_DMA_WDATA, {16'h0000, d});
        rd_word <= d;
        grant <= 1;
        ahb(1, `LHP_OFF_CTRL, {28'h000_0000, m, rd, 1'b1});
        repeat (80) if (done_cnt == c0) @(posedge hclk);
        repeat (4) @(posedge hclk);
        grant <= 0;
        chk(32'(addr_q), 32'(a[7:0]));
        chk(32'(mask_q), 32'(exp_mask(m)));
        chk({dir_oe, xcvr_oe, strobe_oe, byte_lane_mask_1_oe, byte_lane_mask_0_oe}, 0);
        if (rd)
            ahb(0, `LHP_OFF_DMA_RDATA, 0);
        if (rd)
            chk(32'(rdat[15:0]), 32'(d));
        else
            chk(32'(wdata_q), 32'(d));
    endtask
    // host access to the slave ports; on a read w is the lane value expected
    task automatic host(input logic ps, input logic rd, input logic [15:0] w);
        chip_sel_n <= 0;
        port_sel <= ps;
        dir_in <= rd;
        host_word <= w;
        host_drv <= !rd;
        strobe_in <= 0;
        repeat (40) if (slave_ready_oe !== 1'b1) @(posedge hclk);
        chk(32'(slave_ready_oe), 1);
        if (rd)
            chk({lane_oe, lane_out}, {1'b1, w});
        strobe_in <= 1;
        repeat (3) @(posedge hclk);
        chip_sel_n <= 1;
        host_drv <= 0;
        repeat (40) if (slave_ready_oe !== 1'b0) @(posedge hclk);
        chk(32'(slave_ready_oe), 0);
        repeat (2) @(posedge hclk);
    endtask
    initial
    begin
        #(4 * 20000);
        err_total++;
        close_out();
    end
    initial
    begin
        void'($urandom(32'h60f8));
        repeat (6) @(posedge hclk);
        hresetn <= 1;
        chk(32'(attention_irq_oe), 0);
        foreach (rst_offs[i])
        begin
            ahb(0, rst_offs[i], 0);
            chk(rdat, 0);
        end
        ahb(1, `LHP_OFF_CTL_STAT_REG_FOUR, 32'h0000_0041);
        ahb(0, `LHP_OFF_CTL_STAT_REG_FOUR, 0);
        chk(rdat, 32'h0000_0041);
        ahb(1, `LHP_OFF_CTL_STAT_REG_FOUR, 0);
        ahb(1, `LHP_OFF_CTL_STAT_REG_ZERO, 32'h0000_0200);
        repeat (3) @(posedge hclk);
        chk(32'(attention_irq_oe), 0);
        for (int i = 0; i < 12; i++)
            dma(i[2], i[1:0], 16'($urandom), 16'($urandom));
        // burst release pin held active with the release input selected
        ahb(1, `LHP_OFF_CTL_STAT_REG_FOUR, 32'h0000_0040);
        burst_rel_n <= 0;
        dma(1, 2'h0, 16'($urandom), 16'($urandom));
        ahb(0, `LHP_OFF_STAT, 0);
        chk(32'(rdat[4]), 1);
        burst_rel_n <= 1;
        ahb(1, `LHP_OFF_CTL_STAT_REG_FOUR, 0);
        // pointer written and read back through the address port
        hw = 16'($urandom);
        host(1, 0, hw);
        host(1, 1, {8'h00, hw[7:0]});
        hw = 16'($urandom);
        ahb(1, `LHP_OFF_SLV_RDATA, {16'h0000, hw});
        host(0, 1, hw);
        hw = 16'($urandom);
        host(0, 0, hw);
        ahb(0, `LHP_OFF_SLV_WDATA, 0);
        chk(rdat, {16'h0000, hw});
        ahb(0, `LHP_OFF_CTL_STAT_REG_ZERO, 0);
        chk(rdat, 32'h0000_0202);
        chk(32'(attention_irq_oe), 1);
        ahb(1, `LHP_OFF_CTL_STAT_REG_ZERO, 32'h0000_0202);
        repeat (2) @(posedge hclk);
        chk(32'(attention_irq_oe), 0);
        close_out();
    end
endmodule // tb_lhp_host_bus_port
